/* File: ptp_port_cfg.svh */
`ifndef PTP_PORT_CFG_SVH
`define PTP_PORT_CFG_SVH

// Byte offsets within one port's block; the port number sits at [15:12].
`define OFS_RX_LATENCY    12'hC00
`define OFS_TX_LATENCY    12'hC02
`define OFS_ASYMMETRY     12'hC04
`define OFS_REQ_HIGH      12'hC08
`define OFS_REQ_LOW       12'hC0A
`define OFS_SYNC_HIGH     12'hC0C
`define OFS_SYNC_LOW      12'hC0E
`define OFS_RESP_HIGH     12'hC10
`define OFS_RESP_LOW      12'hC12
`define OFS_EVENT_FLAGS   12'hC14
`define OFS_IRQ_ENABLE    12'hC16

// Reset values.
`define RST_RX_LATENCY    16'h019F
`define RST_TX_LATENCY    16'h002D
`define RST_ASYMMETRY     16'h0000
`define RST_STAMP         32'h0000_0000

// Field positions in the asymmetry, flag and enable registers.
`define POS_ASYM_SIGN     15
`define POS_SYNC_FLAG     15
`define POS_REQ_FLAG      14
`define POS_RESP_FLAG     13

// Number of switch ports carrying the block.
`define NUM_PORTS         3

`endif

/* File: ptp_port_pkg.sv */
package ptp_port_pkg;

  // Egress stamp capture for one message kind.
  typedef struct packed {
    logic        valid;
    logic [31:0] stamp;
  } stamp_event_s;

  // Per-port configuration presented to the datapath.
  typedef struct packed {
    logic [15:0] rx_latency_ns;
    logic [15:0] tx_latency_ns;
    logic        asymmetry_sign;
    logic [14:0] asymmetry_magnitude;
  } port_timing_s;

  // Correction field edit requested by the datapath.
  typedef enum logic [1:0] {
    CORR_NONE      = 2'b00,
    CORR_INGRESS   = 2'b01,
    CORR_EGRESS    = 2'b10
  } corr_dir_e;

endpackage

/* File: port_ptp_timestamp_regs.sv */
`timescale 1ns/1ps
`include "ptp_port_cfg.svh"
module port_ptp_timestamp_regs #(
  parameter int NUM_PORTS = `NUM_PORTS
) (
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst_b,
  input  wire logic [15:0]                       i_addr,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  input  wire logic [15:0]                       i_wdata,
  input  wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_sync_evt,
  input  wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_req_evt,
  input  wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_resp_evt,
  input  wire logic [NUM_PORTS-1:0][1:0]         i_corr_dir,
  input  wire logic [NUM_PORTS-1:0][63:0]        i_corr_in,
  output logic      [15:0]                       o_rdata,
  output logic                                   o_rvalid,
  output ptp_port_pkg::port_timing_s [NUM_PORTS-1:0] o_timing,
  output logic      [NUM_PORTS-1:0][63:0]        o_corr_out,
  output logic      [NUM_PORTS-1:0]              o_ptp_irq_status,
  output logic      [NUM_PORTS-1:0]              o_ptp_irq_enable,
  output logic      [NUM_PORTS-1:0]              o_ptp_irq
);

  // Flag mask of the three implemented status and enable bits.
  localparam logic [15:0] FLAG_MASK = (16'h0001 << `POS_SYNC_FLAG) |
                                      (16'h0001 << `POS_REQ_FLAG) |
                                      (16'h0001 << `POS_RESP_FLAG);

  logic [NUM_PORTS-1:0][15:0] rx_lat_reg, rx_lat_next;
  logic [NUM_PORTS-1:0][15:0] tx_lat_reg, tx_lat_next;
  logic [NUM_PORTS-1:0][15:0] asym_reg, asym_next;
  logic [NUM_PORTS-1:0][31:0] req_stamp_reg, req_stamp_next;
  logic [NUM_PORTS-1:0][31:0] sync_stamp_reg, sync_stamp_next;
  logic [NUM_PORTS-1:0][31:0] resp_stamp_reg, resp_stamp_next;
  logic [NUM_PORTS-1:0][15:0] flags_reg, flags_next;
  logic [NUM_PORTS-1:0][15:0] irq_en_reg, irq_en_next;
  logic [NUM_PORTS-1:0][63:0] corr_reg, corr_next;
  logic [15:0]                rdata_reg, rdata_next;
  logic                       rvalid_reg, rvalid_next;

  // Port select from the upper nibble; port N maps to index N-1.
  function automatic logic port_hit(input logic [15:0] addr, input int p);
    port_hit = (addr[15:12] == 4'(p + 1));
  endfunction

  // Signed asymmetry widened to the 64-bit correction field.
  function automatic logic [63:0] asym_value(input logic [15:0] a);
    logic [63:0] mag;
    mag = {49'h0, a[14:0]};
    asym_value = a[`POS_ASYM_SIGN] ? (64'h0 - mag) : mag;
  endfunction

  // Register writes, flag capture and stamp loading for every port.
  always_comb begin
    rx_lat_next     = rx_lat_reg;
    tx_lat_next     = tx_lat_reg;
    asym_next       = asym_reg;
    req_stamp_next  = req_stamp_reg;
    sync_stamp_next = sync_stamp_reg;
    resp_stamp_next = resp_stamp_reg;
    flags_next      = flags_reg;
    irq_en_next     = irq_en_reg;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (i_wr && port_hit(i_addr, p)) begin
        case (i_addr[11:0])
          `OFS_RX_LATENCY: rx_lat_next[p] = i_wdata;
          `OFS_TX_LATENCY: tx_lat_next[p] = i_wdata;
          `OFS_ASYMMETRY:  asym_next[p]   = i_wdata;
          `OFS_EVENT_FLAGS: flags_next[p] = flags_reg[p] & ~i_wdata;
          `OFS_IRQ_ENABLE: irq_en_next[p] = i_wdata & FLAG_MASK;
          default: ;
        endcase
      end
      // Captures come after the clear so a flag set in the same cycle is never lost.
      // Sync flag set
      if (i_sync_evt[p].valid) begin
        sync_stamp_next[p]               = i_sync_evt[p].stamp;
        flags_next[p][`POS_SYNC_FLAG]    = 1'b1;
      end
      if (i_req_evt[p].valid) begin
        req_stamp_next[p]                = i_req_evt[p].stamp;
        flags_next[p][`POS_REQ_FLAG]     = 1'b1;
      end
      if (i_resp_evt[p].valid) begin
        resp_stamp_next[p]               = i_resp_evt[p].stamp;
        flags_next[p][`POS_RESP_FLAG]    = 1'b1;
      end
    end
  end

  // Correction field editing, registered one cycle behind the input.
  always_comb begin
    corr_next = corr_reg;
    for (int p = 0; p < NUM_PORTS; p++) begin
      case (ptp_port_pkg::corr_dir_e'(i_corr_dir[p]))
        ptp_port_pkg::CORR_INGRESS:
          corr_next[p] = i_corr_in[p] + asym_value(asym_reg[p]);
        ptp_port_pkg::CORR_EGRESS:
          corr_next[p] = i_corr_in[p] - asym_value(asym_reg[p]);
        default:
          corr_next[p] = i_corr_in[p];
      endcase
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero.
  always_comb begin
    rdata_next  = 16'h0000;
    rvalid_next = i_rd;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (i_rd && port_hit(i_addr, p)) begin
        case (i_addr[11:0])
          `OFS_RX_LATENCY:  rdata_next = rx_lat_reg[p];
          `OFS_TX_LATENCY:  rdata_next = tx_lat_reg[p];
          `OFS_ASYMMETRY:   rdata_next = asym_reg[p];
          `OFS_REQ_HIGH:    rdata_next = req_stamp_reg[p][31:16];
          `OFS_REQ_LOW:     rdata_next = req_stamp_reg[p][15:0];
          `OFS_SYNC_HIGH:   rdata_next = sync_stamp_reg[p][31:16];
          `OFS_SYNC_LOW:    rdata_next = sync_stamp_reg[p][15:0];
          `OFS_RESP_HIGH:   rdata_next = resp_stamp_reg[p][31:16];
          `OFS_RESP_LOW:    rdata_next = resp_stamp_reg[p][15:0];
          `OFS_EVENT_FLAGS: rdata_next = flags_reg[p];
          `OFS_IRQ_ENABLE:  rdata_next = irq_en_reg[p];
          default:          rdata_next = 16'h0000;
        endcase
      end
    end
  end

  // State registers with synchronous reset.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        rx_lat_reg[p]     <= `RST_RX_LATENCY;
        tx_lat_reg[p]     <= `RST_TX_LATENCY;
        asym_reg[p]       <= `RST_ASYMMETRY;
        req_stamp_reg[p]  <= `RST_STAMP;
        sync_stamp_reg[p] <= `RST_STAMP;
        resp_stamp_reg[p] <= `RST_STAMP;
        flags_reg[p]      <= 16'h0000;
        irq_en_reg[p]     <= 16'h0000;
        corr_reg[p]       <= 64'h0000_0000_0000_0000;
      end
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rx_lat_reg     <= rx_lat_next;
      tx_lat_reg     <= tx_lat_next;
      asym_reg       <= asym_next;
      req_stamp_reg  <= req_stamp_next;
      sync_stamp_reg <= sync_stamp_next;
      resp_stamp_reg <= resp_stamp_next;
      flags_reg      <= flags_next;
      irq_en_reg     <= irq_en_next;
      corr_reg       <= corr_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
    end
  end

  // Outputs and per-port summaries.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      o_timing[p].rx_latency_ns       = rx_lat_reg[p];
      o_timing[p].tx_latency_ns       = tx_lat_reg[p];
      o_timing[p].asymmetry_sign      = asym_reg[p][`POS_ASYM_SIGN];
      o_timing[p].asymmetry_magnitude = asym_reg[p][14:0];
      o_ptp_irq_status[p] = |(flags_reg[p] & FLAG_MASK);
      o_ptp_irq_enable[p] = |irq_en_reg[p];
      o_ptp_irq[p]        = |(flags_reg[p] & irq_en_reg[p]);
    end
  end

  assign o_corr_out = corr_reg;
  assign o_rdata    = rdata_reg;
  assign o_rvalid   = rvalid_reg;

endmodule

/* File: port_ptp_timestamp_regs_sva.sv */
`timescale 1ns/1ps
module ptp_regs_checker #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                                   i_clk_sys,
  input wire logic                                   i_rst_b,
  input wire logic                                   i_wr,
  input wire logic                                   i_rd,
  input wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_sync_evt,
  input wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_req_evt,
  input wire ptp_port_pkg::stamp_event_s [NUM_PORTS-1:0] i_resp_evt,
  input wire logic [NUM_PORTS-1:0][1:0]              i_corr_dir,
  input wire logic [NUM_PORTS-1:0][63:0]             i_corr_in,
  input wire logic                                   o_rvalid,
  input wire ptp_port_pkg::port_timing_s [NUM_PORTS-1:0] o_timing,
  input wire logic [NUM_PORTS-1:0][63:0]             o_corr_out,
  input wire logic [NUM_PORTS-1:0]                   o_ptp_irq_status,
  input wire logic [NUM_PORTS-1:0]                   o_ptp_irq_enable,
  input wire logic [NUM_PORTS-1:0]                   o_ptp_irq
);
  logic [63:0] adj;
  // Sign-magnitude asymmetry of port 1 as two's complement, for reference.
  assign adj = o_timing[0].asymmetry_sign
    ? -{49'h0, o_timing[0].asymmetry_magnitude}
    : {49'h0, o_timing[0].asymmetry_magnitude};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_answer;
    ##1 o_rvalid;
  endsequence
  a_read_answers: assert property (i_rd |-> s_answer)
    else $error("read not answered");
  a_no_stray_rvalid: assert property (!i_rd |=> !o_rvalid)
    else $error("read answer without read");
  a_sync_flag_sets: assert property (i_sync_evt[0].valid |=> o_ptp_irq_status[0])
    else $error("sync flag not set");
  a_req_flag_sets: assert property (i_req_evt[0].valid |=> o_ptp_irq_status[0])
    else $error("request flag not set");
  a_resp_flag_sets: assert property (i_resp_evt[0].valid |=> o_ptp_irq_status[0])
    else $error("response flag not set");
  a_flag_holds: assert property (o_ptp_irq_status[0] && !i_wr |=> o_ptp_irq_status[0])
    else $error("flag lost without write");
  a_flag_cause: assert property ($rose(o_ptp_irq_status[0]) |->
    $past(i_sync_evt[0].valid | i_req_evt[0].valid | i_resp_evt[0].valid))
    else $error("flag set without capture");
  a_irq_masked: assert property ((o_ptp_irq & ~(o_ptp_irq_status & o_ptp_irq_enable)) == 0)
    else $error("interrupt not gated");
  a_ingress_adds: assert property (i_corr_dir[0] == 2'h1 |=>
    o_corr_out[0] == $past(i_corr_in[0]) + $past(adj))
    else $error("ingress correction wrong");
  a_egress_subtracts: assert property (i_corr_dir[0] == 2'h2 |=>
    o_corr_out[0] == $past(i_corr_in[0]) - $past(adj))
    else $error("egress correction wrong");
endmodule
bind port_ptp_timestamp_regs ptp_regs_checker #(.NUM_PORTS(NUM_PORTS)) chk_i (.*);

/* File: tb_port_ptp_timestamp_regs.sv */
`timescale 1ns/1ps
module tb_port_ptp_timestamp_regs;
  logic                             i_clk_sys = 1'b0;
  logic                             i_rst_b = 1'b0;
  logic [15:0]                      i_addr = 16'h0000;
  logic                             i_wr = 1'b0;
  logic                             i_rd = 1'b0;
  logic [15:0]                      i_wdata = 16'h0000;
  ptp_port_pkg::stamp_event_s [2:0] i_sync_evt = '0;
  ptp_port_pkg::stamp_event_s [2:0] i_req_evt = '0;
  ptp_port_pkg::stamp_event_s [2:0] i_resp_evt = '0;
  logic [2:0][1:0]                  i_corr_dir = '0;
  logic [2:0][63:0]                 i_corr_in = '0;
  logic [15:0]                      o_rdata;
  logic                             o_rvalid;
  ptp_port_pkg::port_timing_s [2:0] o_timing;
  logic [2:0][63:0]                 o_corr_out;
  logic [2:0]                       o_ptp_irq_status;
  logic [2:0]                       o_ptp_irq_enable;
  logic [2:0]                       o_ptp_irq;
  int                               fail_count = 0;
  int                               compares = 0;
  logic [11:0]                      hi_ofs [3] = '{12'hC0C, 12'hC08, 12'hC10};
  logic [15:0]                      flag [3] = '{16'h8000, 16'h4000, 16'h2000};

  // Free-running system clock, 50 ns period.
  always #25 i_clk_sys = ~i_clk_sys;

  port_ptp_timestamp_regs port_ptp_timestamp_regs_i (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .i_sync_evt(i_sync_evt), .i_req_evt(i_req_evt),
    .i_resp_evt(i_resp_evt), .i_corr_dir(i_corr_dir), .i_corr_in(i_corr_in),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_timing(o_timing),
    .o_corr_out(o_corr_out), .o_ptp_irq_status(o_ptp_irq_status),
    .o_ptp_irq_enable(o_ptp_irq_enable), .o_ptp_irq(o_ptp_irq));

  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobes last one cycle; inputs move on the falling edge only.
  task automatic wr(int p, logic [11:0] ofs, logic [15:0] d);
    @(negedge i_clk_sys);
    i_addr = {4'(p), ofs};
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk_sys);
    i_wr = 1'b0;
  endtask

  // The answer stands for exactly the cycle after the read edge.
  task automatic rd(int p, logic [11:0] ofs, logic [15:0] exp);
    @(negedge i_clk_sys);
    i_addr = {4'(p), ofs};
    i_rd = 1'b1;
    @(negedge i_clk_sys);
    i_rd = 1'b0;
    chk("rvalid", o_rvalid, 1'b1);
    chk("rdata", o_rdata, exp);
  endtask

  task automatic evt(int k, int p, logic [31:0] s);
    @(negedge i_clk_sys);
    if (k == 0) i_sync_evt[p] = {1'b1, s};
    else if (k == 1) i_req_evt[p] = {1'b1, s};
    else i_resp_evt[p] = {1'b1, s};
    @(negedge i_clk_sys);
    i_sync_evt[p].valid = 1'b0;
    i_req_evt[p].valid = 1'b0;
    i_resp_evt[p].valid = 1'b0;
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence; offset 0xC06 in the reset sweep is the unmapped hole.
  initial begin
    logic [15:0] acc;
    logic [15:0] a;
    repeat (8) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    for (int p = 1; p <= 3; p++)
      for (int i = 0; i < 12; i++)
        rd(p, 12'hC00 + 12'(2 * i), i == 0 ? 16'h019F : i == 1 ? 16'h002D : 16'h0000);
    for (int p = 1; p <= 3; p++) begin
      wr(p, 12'hC00, 16'h1000 + 16'(p));
      wr(p, 12'hC02, 16'h2000 + 16'(p));
      wr(p, 12'hC08, 16'hFFFF);
    end
    for (int p = 1; p <= 3; p++) begin
      rd(p, 12'hC00, 16'h1000 + 16'(p));
      rd(p, 12'hC02, 16'h2000 + 16'(p));
      chk("rx_lat", o_timing[p-1].rx_latency_ns, 16'h1000 + 16'(p));
      chk("tx_lat", o_timing[p-1].tx_latency_ns, 16'h2000 + 16'(p));
      rd(p, 12'hC08, 16'h0000);
    end
    @(negedge i_clk_sys);
    i_corr_in[0] = 64'd1000;
    i_corr_dir[0] = 2'h1;
    @(negedge i_clk_sys);
    chk("corr_zero", o_corr_out[0], 64'd1000);
    for (int j = 0; j < 2; j++) begin
      a = j ? 16'h0005 : 16'h8005;
      wr(1, 12'hC04, a);
      chk("sign", o_timing[0].asymmetry_sign, a[15]);
      chk("magnitude", o_timing[0].asymmetry_magnitude, 15'h0005);
      for (int d = 1; d <= 2; d++) begin
        i_corr_dir[0] = 2'(d);
        @(negedge i_clk_sys);
        chk("corr", o_corr_out[0], ((d == 1) ^ a[15]) ? 64'd1005 : 64'd995);
      end
    end
    i_corr_dir[0] = 2'h0;
    @(negedge i_clk_sys);
    chk("corr_idle", o_corr_out[0], 64'd1000);
    i_corr_dir[0] = 2'h3;
    @(negedge i_clk_sys);
    chk("corr_none", o_corr_out[0], 64'd1000);
    i_corr_dir[0] = 2'h0;
    for (int p = 0; p < 3; p++) begin
      acc = 16'h0000;
      for (int k = 0; k < 3; k++) begin
        evt(k, p, {16'(16'hA000 + k), 16'(16'h0B00 + p)});
        acc = acc | flag[k];
        rd(p + 1, hi_ofs[k], 16'(16'hA000 + k));
        rd(p + 1, hi_ofs[k] + 12'h002, 16'(16'h0B00 + p));
        rd(p + 1, 12'hC14, acc);
      end
    end
    chk("irq_status", o_ptp_irq_status, 3'b111);
    chk("irq_masked", o_ptp_irq, 3'b000);
    for (int p = 1; p <= 3; p++) begin
      wr(p, 12'hC16, 16'hFFFF);
      rd(p, 12'hC16, 16'hE000);
    end
    chk("irq_enable", o_ptp_irq_enable, 3'b111);
    chk("irq", o_ptp_irq, 3'b111);
    for (int p = 1; p <= 3; p++) begin
      wr(p, 12'hC14, 16'h8000);
      rd(p, 12'hC14, 16'h6000);
      wr(p, 12'hC14, 16'h7FFF);
      rd(p, 12'hC14, 16'h0000);
    end
    chk("irq_cleared", o_ptp_irq_status, 3'b000);
    chk("irq_off", o_ptp_irq, 3'b000);
    final_report();
  end
endmodule
